// [logic/glpp_regs.svh]
// Constants of the grayscale latch and segmented PWM path
`ifndef GLPP_REGS_SVH
`define GLPP_REGS_SVH

`define GLPP_CHANNELS      16
`define GLPP_WORD_W        16
`define GLPP_ADDR_W        4
`define GLPP_WORD_RESET    16'h0000
`define GLPP_COUNT_RESET   16'h0000
`define GLPP_COUNT_MAX     16'hffff
`define GLPP_ARM_COUNT     16'h0200
`define GLPP_BIT_RESET     4'h0
`define GLPP_BIT_LAST      4'hf
`define GLPP_ADDR_RESET    4'h0
`define GLPP_SEG_W         7
`define GLPP_POS_W         9
`define GLPP_FC_REFRESH_BIT 10

`endif

// [logic/glpp_pkg.sv]
// Types of the grayscale latch and segmented PWM path
package glpp_pkg;
	typedef enum logic [2:0] {
		disp_blank = 3'b001,
		disp_arm   = 3'b010,
		disp_run   = 3'b100
	} glpp_disp_t;
endpackage

// [logic/glpp_buf2.sv]
// Two-entry valid/ready buffer
`timescale 1ns/100ps
module glpp_buf2 #(
	parameter int WIDTH = 16
) (
	input  wire logic             clk_sys,
	input  wire logic             reset_n,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic [WIDTH-1:0]      out_data
);
	logic [WIDTH-1:0] slot0;
	logic [WIDTH-1:0] slot1;
	logic [1:0]       fill;
	logic             push;
	logic             pop;

	assign in_ready  = (fill != 2'h2);
	assign out_valid = (fill != 2'h0);
	assign out_data  = slot0;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			fill <= 2'h0;
		end else if (clk_en) begin
			fill <= 2'(fill + {1'b0, push} - {1'b0, pop});
		end
	end

	// Slot 0 is always the head, so the reader sees no mux
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			slot0 <= '0;
			slot1 <= '0;
		end else if (clk_en) begin
			if (pop) begin
				slot0 <= (fill == 2'h2) ? slot1 : in_data;
			end else if (push && fill == 2'h0) begin
				slot0 <= in_data;
			end
			if (push && ((fill == 2'h1 && !pop) || fill == 2'h2)) begin
				slot1 <= in_data;
			end
		end
	end
endmodule // glpp_buf2

// [logic/glpp_path.sv]
// Serial shift register, three grayscale latch stages and segmented PWM
`timescale 1ns/100ps
`include "glpp_regs.svh"
module glpp_path #(
	parameter int CHANNELS = `GLPP_CHANNELS
) (
	input  wire logic                clk_sys,
	input  wire logic                reset_n,
	input  wire logic                clk_en,
	input  wire logic                shift_clock,
	input  wire logic                serial_data_in,
	input  wire logic                transfer_strobe,
	input  wire logic                write_shade_cmd,
	input  wire logic                commit_shade_cmd,
	input  wire logic                refresh_disable_bit,
	input  wire logic                shade_clock,
	output logic                     serial_data_out,
	output logic [CHANNELS-1:0]      channel_output
);
	localparam int W = `GLPP_WORD_W;

	// Link side
	logic         en_l1;
	logic         en_l2;
	logic         strobe_l1;
	logic         strobe_l2;
	logic         ack_l1;
	logic         ack_l2;
	logic [W-1:0] shift_reg;
	logic [3:0]   bit_cnt;
	logic [W-1:0] word_hold;
	logic         req_tgl;
	logic [W-1:0] next_shift;

	// System side
	logic         req_s1;
	logic         req_s2;
	logic         req_seen;
	logic         shade_s1;
	logic         shade_s2;
	logic         shade_s3;
	logic         shade_edge;
	logic         buf_in_ready;
	logic         buf_valid;
	logic [W-1:0] buf_data;
	logic [`GLPP_ADDR_W-1:0] addr;
	logic [W-1:0] stage1 [CHANNELS];
	logic [W-1:0] stage2 [CHANNELS];
	logic [W-1:0] stage3 [CHANNELS];
	logic [W-1:0] shade_count;
	logic         wrap;
	logic         hard_commit;
	logic         soft_commit;
	logic         load_pending;
	logic [CHANNELS-1:0] next_on;
	glpp_pkg::glpp_disp_t disp;
	glpp_pkg::glpp_disp_t next_disp;

	assign next_shift = {shift_reg[W-2:0], serial_data_in};

	always_ff @(posedge shift_clock or negedge reset_n) begin
		if (!reset_n) begin
			en_l1     <= 1'b0;
			en_l2     <= 1'b0;
			strobe_l1 <= 1'b0;
			strobe_l2 <= 1'b0;
			ack_l1    <= 1'b0;
			ack_l2    <= 1'b0;
		end else begin
			en_l1     <= clk_en;
			en_l2     <= en_l1;
			strobe_l1 <= transfer_strobe;
			strobe_l2 <= strobe_l1;
			ack_l1    <= req_seen;
			ack_l2    <= ack_l1;
		end
	end

	always_ff @(posedge shift_clock or negedge reset_n) begin
		if (!reset_n) begin
			shift_reg       <= `GLPP_WORD_RESET;
			serial_data_out <= 1'b0;
		end else if (en_l2) begin
			shift_reg       <= next_shift;
			serial_data_out <= shift_reg[W-2];
		end
	end

	// A strobe realigns word framing; a word waiting for ack is not overwritten
	always_ff @(posedge shift_clock or negedge reset_n) begin
		if (!reset_n) begin
			bit_cnt   <= `GLPP_BIT_RESET;
			word_hold <= `GLPP_WORD_RESET;
			req_tgl   <= 1'b0;
		end else if (en_l2) begin
			if (strobe_l2) begin
				bit_cnt <= `GLPP_BIT_RESET;
			end else begin
				bit_cnt <= 4'(bit_cnt + 4'h1);
				if (bit_cnt == `GLPP_BIT_LAST && req_tgl == ack_l2) begin
					word_hold <= next_shift;
					req_tgl   <= ~req_tgl;
				end
			end
		end
	end

	// Only the flops after the first of each synchroniser feed logic
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			req_s1   <= 1'b0;
			req_s2   <= 1'b0;
			shade_s1 <= 1'b0;
			shade_s2 <= 1'b0;
			shade_s3 <= 1'b0;
		end else if (clk_en) begin
			req_s1   <= req_tgl;
			req_s2   <= req_s1;
			shade_s1 <= shade_clock;
			shade_s2 <= shade_s1;
			shade_s3 <= shade_s2;
		end
	end

	assign shade_edge = clk_en && shade_s2 && !shade_s3;

	// Word is held stable on the link side until req_seen comes back
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			req_seen <= 1'b0;
		end else if (clk_en && (req_s2 != req_seen) && buf_in_ready) begin
			req_seen <= req_s2;
		end
	end

	glpp_buf2 #(
		.WIDTH(W)
	) u_buf (
		.clk_sys  (clk_sys),
		.reset_n  (reset_n),
		.clk_en   (clk_en),
		.in_valid (req_s2 != req_seen),
		.in_ready (buf_in_ready),
		.in_data  (word_hold),
		.out_valid(buf_valid),
		.out_ready(write_shade_cmd && clk_en),
		.out_data (buf_data)
	);

	assign hard_commit = clk_en && commit_shade_cmd && refresh_disable_bit;
	assign soft_commit = clk_en && commit_shade_cmd && !refresh_disable_bit;
	assign wrap = shade_edge && (shade_count == `GLPP_COUNT_MAX);

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			addr <= `GLPP_ADDR_RESET;
		end else if (clk_en) begin
			if (commit_shade_cmd) begin
				addr <= `GLPP_ADDR_RESET;
			end else if (write_shade_cmd) begin
				addr <= `GLPP_ADDR_W'(addr + 1'b1);
			end
		end
	end

	generate
		for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
			logic [`GLPP_SEG_W-1:0] seg;
			logic [`GLPP_SEG_W-1:0] seg_rev;
			logic [`GLPP_POS_W:0]   thr;

			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					stage1[ch] <= '0;
				end else if (clk_en && write_shade_cmd && buf_valid &&
					addr == `GLPP_ADDR_W'(ch)) begin
					stage1[ch] <= buf_data;
				end
			end

			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					stage2[ch] <= '0;
				end else if (clk_en && commit_shade_cmd) begin
					stage2[ch] <= stage1[ch];
				end
			end

			// Deferred load at the wrap keeps a period from tearing
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					stage3[ch] <= '0;
				end else if (hard_commit) begin
					stage3[ch] <= stage1[ch];
				end else if (wrap) begin
					stage3[ch] <= stage2[ch];
				end
			end

			// Extra clock lands in bit-reversed segment order
			assign seg = shade_count[W-1:`GLPP_POS_W];
			for (genvar b = 0; b < `GLPP_SEG_W; b++) begin : g_rev
				assign seg_rev[b] = seg[`GLPP_SEG_W-1-b];
			end
			assign thr = {1'b0, stage3[ch][W-1:`GLPP_SEG_W]} +
				{{`GLPP_POS_W{1'b0}},
				(seg_rev < stage3[ch][`GLPP_SEG_W-1:0])};
			assign next_on[ch] = ({1'b0, shade_count[`GLPP_POS_W-1:0]} <
				thr);
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			shade_count <= `GLPP_COUNT_RESET;
		end else if (hard_commit) begin
			shade_count <= `GLPP_COUNT_RESET;
		end else if (shade_edge) begin
			shade_count <= W'(shade_count + 1'b1);
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			load_pending <= 1'b0;
		end else if (hard_commit || (wrap && !soft_commit)) begin
			load_pending <= 1'b0;
		end else if (soft_commit) begin
			load_pending <= 1'b1;
		end
	end

	always_comb begin
		next_disp = disp;
		case (disp)
			glpp_pkg::disp_blank: begin
				if (hard_commit || (wrap && load_pending)) begin
					next_disp = glpp_pkg::disp_arm;
				end
			end
			glpp_pkg::disp_arm: begin
				if (!hard_commit && shade_edge &&
					shade_count == `GLPP_ARM_COUNT) begin
					next_disp = glpp_pkg::disp_run;
				end
			end
			glpp_pkg::disp_run: begin
				if (hard_commit) begin
					next_disp = glpp_pkg::disp_arm;
				end
			end
			default: next_disp = glpp_pkg::disp_blank;
		endcase
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			disp <= glpp_pkg::disp_blank;
		end else if (clk_en) begin
			disp <= next_disp;
		end
	end

	// Outputs change on shade edges, save that a direct commit clears them at once
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			channel_output <= '0;
		end else if (hard_commit) begin
			channel_output <= '0;
		end else if (shade_edge) begin
			channel_output <= (next_disp == glpp_pkg::disp_run) ?
				next_on : '0;
		end
	end

	property p_shift;
		@(posedge shift_clock) disable iff (!reset_n)
		en_l2 |=> shift_reg == {$past(shift_reg[W-2:0]),
			$past(serial_data_in)} && serial_data_out == shift_reg[W-1];
	endproperty
	a_shift: assert property (p_shift)
		else $error("shift register did not move one place");

	property p_write;
		@(posedge clk_sys) disable iff (!reset_n)
		clk_en && write_shade_cmd && buf_valid && addr == 4'h3 |=>
			stage1[3] == $past(buf_data);
	endproperty
	a_write: assert property (p_write)
		else $error("write did not land in addressed slot");

	property p_soft;
		@(posedge clk_sys) disable iff (!reset_n)
		soft_commit && !wrap |=> stage2[0] == $past(stage1[0]) &&
			stage3[0] == $past(stage3[0]);
	endproperty
	a_soft: assert property (p_soft)
		else $error("refresh commit touched third stage early");

	property p_hard;
		@(posedge clk_sys) disable iff (!reset_n)
		hard_commit |=> stage3[1] == $past(stage1[1]) &&
			stage2[1] == $past(stage1[1]);
	endproperty
	a_hard: assert property (p_hard)
		else $error("direct commit did not fill both stages");

	property p_force_off;
		@(posedge clk_sys) disable iff (!reset_n)
		hard_commit |=> shade_count == `GLPP_COUNT_RESET &&
			channel_output == '0 && disp == glpp_pkg::disp_arm;
	endproperty
	a_force_off: assert property (p_force_off)
		else $error("direct commit did not clear counter and outputs");

	property p_dark;
		@(posedge clk_sys) disable iff (!reset_n)
		disp != glpp_pkg::disp_run |-> ##1 channel_output == '0 ||
			disp == glpp_pkg::disp_run;
	endproperty
	a_dark: assert property (p_dark)
		else $error("output on before display armed");

	property p_arm;
		@(posedge clk_sys) disable iff (!reset_n)
		disp == glpp_pkg::disp_arm && shade_edge && !hard_commit &&
			shade_count == `GLPP_ARM_COUNT |=> disp == glpp_pkg::disp_run;
	endproperty
	a_arm: assert property (p_arm)
		else $error("outputs not enabled at 513th shade clock");

	property p_count;
		@(posedge clk_sys) disable iff (!reset_n)
		shade_edge && !hard_commit |=>
			shade_count == 16'($past(shade_count) + 16'h0001);
	endproperty
	a_count: assert property (p_count)
		else $error("grayscale counter did not advance");

	property p_addr;
		@(posedge clk_sys) disable iff (!reset_n)
		clk_en && commit_shade_cmd |=> addr == `GLPP_ADDR_RESET;
	endproperty
	a_addr: assert property (p_addr)
		else $error("address counter not returned after commit");

	c_word: cover property (@(posedge clk_sys) disable iff (!reset_n)
		buf_valid && write_shade_cmd);
	c_run: cover property (@(posedge clk_sys) disable iff (!reset_n)
		disp == glpp_pkg::disp_arm ##1 disp == glpp_pkg::disp_run);
	c_wrap: cover property (@(posedge clk_sys) disable iff (!reset_n)
		wrap && load_pending);
endmodule // glpp_path

// [test/glpp_ctrl_model.sv]
// Display controller model driving the serial link and shade clock
`timescale 1ns/100ps
module glpp_ctrl_model (
	input  wire logic clk_sys,
	output logic      shift_clock,
	output logic      serial_data_in,
	output logic      transfer_strobe,
	output logic      shade_clock
);
	initial begin
		shift_clock = 1'b0;
		serial_data_in = 1'b0;
		transfer_strobe = 1'b0;
		shade_clock = 1'b0;
	end
	// Link clock only runs inside frames, 15 ns period
	task automatic shift_bit(input logic b);
		serial_data_in = b;
		#7.5 shift_clock = 1'b1;
		#7.5 shift_clock = 1'b0;
	endtask
	// Idle edges so the link side sees its enable
	task automatic wake();
		shift_bit(1'b1);
		shift_bit(1'b0);
		serial_data_in = 1'b1;
	endtask
	// First bit sent lands at the MSB
	task automatic send_word(input logic [15:0] w);
		#($urandom_range(1, 40));
		for (int i = 15; i >= 0; i--) begin
			shift_bit(w[i]);
		end
		// Released line shows the inverse, not a held value
		serial_data_in = ~w[0];
	endtask
	// Stray bits, then a strobe; two edges pass while it clears the flops
	task automatic realign();
		repeat (5) shift_bit(1'b1);
		transfer_strobe = 1'b1;
		repeat (3) shift_bit(1'b0);
		transfer_strobe = 1'b0;
		repeat (2) shift_bit(1'b0);
	endtask
	// Each level held three system cycles, above the two needed
	task automatic shade_edge();
		repeat (3) @(negedge clk_sys);
		shade_clock = 1'b1;
		repeat (3) @(negedge clk_sys);
		shade_clock = 1'b0;
	endtask
endmodule // glpp_ctrl_model

// [test/tb_top.sv]
// Self-checking bench for the grayscale latch and PWM path
`timescale 1ns/100ps
module tb_top;
	logic        clk_sys;
	logic        reset_n;
	logic        write_shade_cmd;
	logic        commit_shade_cmd;
	logic        refresh_disable_bit;
	logic        shift_clock;
	logic        serial_data_in;
	logic        transfer_strobe;
	logic        shade_clock;
	logic        serial_data_out;
	logic [15:0] channel_output;
	logic        clk_en;
	logic [15:0] exp_out;
	int          n_mismatch;
	int          cmp_count;
	int          count;
	logic [15:0] st1 [16];
	logic [15:0] st3 [16];
	logic [15:0] fixed [6] = '{16'h0100, 16'h0000, 16'hffff,
		16'h0101, 16'hff80, 16'h0041};

	glpp_path dut_u (
		.clk_sys             (clk_sys),
		.reset_n             (reset_n),
		.clk_en              (clk_en),
		.shift_clock         (shift_clock),
		.serial_data_in      (serial_data_in),
		.transfer_strobe     (transfer_strobe),
		.write_shade_cmd     (write_shade_cmd),
		.commit_shade_cmd    (commit_shade_cmd),
		.refresh_disable_bit (refresh_disable_bit),
		.shade_clock         (shade_clock),
		.serial_data_out     (serial_data_out),
		.channel_output      (channel_output)
	);

	glpp_ctrl_model ctl_u (
		.clk_sys         (clk_sys),
		.shift_clock     (shift_clock),
		.serial_data_in  (serial_data_in),
		.transfer_strobe (transfer_strobe),
		.shade_clock     (shade_clock)
	);

	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Segment from top count bits, spread order by bit reversal
	function automatic logic pwm_on(input logic [15:0] v, input int c);
		logic [15:0] cc;
		logic [6:0]  rev;
		int          pos;
		cc = c[15:0];
		pos = int'(cc[8:0]);
		for (int i = 0; i < 7; i++) begin
			rev[i] = cc[15 - i];
		end
		return c >= 512 && pos < int'(v[15:7]) + int'(rev < v[6:0]);
	endfunction

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic write_once();
		write_shade_cmd = 1'b1;
		@(negedge clk_sys);
		write_shade_cmd = 1'b0;
	endtask

	// Writes lag one word so the buffer holds two at times
	task automatic load_all(input logic [15:0] mask);
		logic [15:0] w;
		for (int k = 0; k < 16; k++) begin
			if (k == 0 && mask != 16'h0000) begin
				ctl_u.realign();
			end
			w = (k < 6) ? fixed[k] ^ mask : 16'($urandom());
			ctl_u.send_word(w);
			check("serial_data_out", {15'h0, w[15]}, {15'h0, serial_data_out});
			st1[k] = w;
			repeat (10) @(negedge clk_sys);
			if (k > 0) begin
				write_once();
			end
		end
		@(negedge clk_sys);
		write_once();
	endtask

	task automatic commit(input logic rd);
		commit_shade_cmd = 1'b1;
		refresh_disable_bit = rd;
		@(negedge clk_sys);
		commit_shade_cmd = 1'b0;
		if (rd) begin
			st3 = st1;
			count = 0;
		end
	endtask

	task automatic shade_step(input int n);
		repeat (n) begin
			ctl_u.shade_edge();
			for (int k = 0; k < 16; k++) begin
				exp_out[k] = pwm_on(st3[k], count);
			end
			count = (count + 1) % 65536;
			check("channel_output", exp_out, channel_output);
		end
	endtask

	task automatic close_out();
		$display("Counts: %0d compares, %0d mismatches", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Whole run needs about 12000 cycles
	initial begin
		repeat (40000) @(posedge clk_sys);
		n_mismatch++;
		close_out();
	end

	initial begin
		void'($urandom(33912));
		reset_n = 1'b0;
		write_shade_cmd = 1'b0;
		commit_shade_cmd = 1'b0;
		refresh_disable_bit = 1'b0;
		n_mismatch = 0;
		cmp_count = 0;
		count = 0;
		clk_en = 1'b1;
		exp_out = 16'h0000;
		for (int k = 0; k < 16; k++) begin
			st3[k] = 16'h0000;
		end
		ctl_u.wake();
		repeat (3) @(negedge clk_sys);
		reset_n = 1'b1;
		check("serial_data_out", 16'h0000, {15'h0, serial_data_out});
		check("channel_output", 16'h0000, channel_output);
		ctl_u.wake();
		load_all(16'h0000);
		shade_step(20);
		$display("TEST blank_until_loaded done");
		commit(1'b1);
		check("channel_output", 16'h0000, channel_output);
		shade_step(1100);
		$display("TEST direct_commit_pwm done");
		clk_en = 1'b0;
		ctl_u.shade_edge();
		check("frozen channel_output", exp_out, channel_output);
		clk_en = 1'b1;
		$display("TEST clock_enable_freeze done");
		load_all(16'h0081);
		commit(1'b0);
		shade_step(200);
		$display("TEST deferred_commit done");
		commit(1'b1);
		check("channel_output", 16'h0000, channel_output);
		shade_step(600);
		$display("TEST recommit_direct done");
		close_out();
	end
endmodule // tb_top
